// ### asp_params.svh
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define ASP_OFS_CTRL 4'h0
`define ASP_OFS_STATUS 4'h4
`define ASP_OFS_MASK 4'h8
`define ASP_OFS_STATE 4'hc
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASP_CTRL_EN 0
`define ASP_EV_CONV 0
`define ASP_EV_READ 1
`define ASP_EV_ERR 2
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define ASP_CTRL_RST 1'b1
`define ASP_MASK_RST 3'h0
`define ASP_RESULT_BITS 16
// Half-period of the master clock in I_CLK cycles per divide code
`define ASP_DIV0 8'h02
`define ASP_DIV1 8'h04
`define ASP_DIV2 8'h08
`define ASP_DIV3 8'h10
`endif

// ### asp_pkg.sv
package asp_pkg;
	// Serial port configuration from the mode pins and the shared pins
	typedef struct packed {
		logic serial;
		logic slave;
		logic sync_polarity_select;
		logic serial_clock_invert;
		logic read_mode_or_chain_in;
		logic output_format_select;
		logic [1:0] serial_clock_divide;
	} asp_cfg_t;
	// Read sequence state
	typedef enum logic [1:0] {ASP_IDLE, ASP_MASTER, ASP_SLAVE} asp_state_t;
endpackage

// ### asp_sync.sv
// Two flip-flop synchroniser for pin inputs
module asp_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta; // First stage, read only by the second
	// Second stage feeds the logic
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta <= '0;
			o_q <= '0;
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule

// ### asp_clkdiv.sv
`include "asp_params.svh"
// Half-period tick generator for the master serial clock
module asp_clkdiv import asp_pkg::*; (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_run,
	input wire logic [1:0] i_code,
	output logic o_tick
);
	logic [7:0] cnt; // Cycles since last tick
	logic [7:0] half; // Selected half-period
	// Fixed ratio per divide code
	always_comb begin
		case (i_code)
			2'h0: half = `ASP_DIV0;
			2'h1: half = `ASP_DIV1;
			2'h2: half = `ASP_DIV2;
			default: half = `ASP_DIV3;
		endcase
	end
	// Count restarts whenever the shifter is idle, so the first half-period is full
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt <= 8'h00;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			cnt <= 8'h00;
			o_tick <= 1'b0;
		end else if (cnt >= half - 8'h01) begin
			cnt <= 8'h00;
			o_tick <= 1'b1;
		end else begin
			cnt <= cnt + 8'h01;
			o_tick <= 1'b0;
		end
	end
endmodule

// ### asp_top.sv
// Local design decisions: the APB register port and the placing of the registers.
`include "asp_params.svh"
// How it works
// - Master read-after-convert uses divide pins
// - Divide pins tri-stated in other serial modes
// - Parallel mode drives shared pins as bits
// - Master mode drives internal clock out
// - Slave clock from host, gated by select
// - Sync polarity chosen by pin
// - Clock invert pin in both modes
// - Chain input appears after 16 clocks
// - Read-during outputs previous result
// - Read-after waits for conversion end
// - MSB first, binary or twos complement
// - Sync active while master data valid
// - Slave read unfinished at conversion end flags error
// - Busy from start until result latched
module asp_top import asp_pkg::*; #(
	parameter int BITS = `ASP_RESULT_BITS
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RESETN,
	// Conversion core
	input wire logic I_CONV_START,
	input wire logic I_CONV_DONE,
	input wire logic [BITS-1:0] I_CONV_DATA,
	// Mode pins and host strobes
	input wire logic I_SERIAL_PARALLEL_SELECT,
	input wire logic I_OUTPUT_FORMAT_SELECT,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	// Shared pins, data bits 2 to 7
	input wire logic [5:0] I_SHARED,
	output logic [5:0] O_SHARED,
	output logic [5:0] O_SHARED_OE,
	// Serial clock pin
	input wire logic I_SCLK,
	output logic O_SCLK,
	output logic O_SCLK_OE,
	// Serial outputs
	output logic O_SERIAL_RESULT_OUT,
	output logic O_SYNC,
	output logic O_INCOMPLETE_READ_FLAG,
	output logic O_BUSY,
	output logic O_IRQ,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [3:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	initial begin
		if (BITS < 8 || BITS > 31) $error("BITS out of range");
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [11:0] pins_s; // Synchronised pin levels
	asp_sync #(.W(12)) u_sync (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_d({I_SHARED, I_SCLK, I_RD_N, I_CS_N, I_OUTPUT_FORMAT_SELECT,
			I_SERIAL_PARALLEL_SELECT, 1'b0}),
		.o_q(pins_s)
	);
	logic cs_act; // Chip select and read both low
	logic sclk_s; // Synchronised external clock
	asp_cfg_t cfg; // Decoded configuration
	assign cs_act = !pins_s[4] && !pins_s[3];
	assign sclk_s = pins_s[5];
	always_comb begin
		cfg.serial = pins_s[1];
		cfg.output_format_select = pins_s[2];
		cfg.slave = pins_s[8];
		cfg.sync_polarity_select = pins_s[9];
		cfg.serial_clock_invert = pins_s[10];
		cfg.read_mode_or_chain_in = pins_s[11];
		// Divide pins only count in master read-after-convert
		cfg.serial_clock_divide = (!pins_s[8] && !pins_s[11]) ? pins_s[7:6] : 2'h0;
	end

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic ctrl_en; // Software enable for new read sequences
	logic [2:0] status; // Sticky events
	logic [2:0] mask; // Interrupt mask
	asp_state_t state; // Read sequence state
	logic [BITS-1:0] result; // Latched, formatted result
	logic [BITS-1:0] shreg; // Output shift register
	logic [4:0] bit_cnt; // Bits shifted so far
	logic sclk_int; // Internal master clock level
	logic sclk_eff_d; // Previous effective external clock
	logic tick; // Master half-period tick
	logic rd_ok; // Result not yet read
	logic ev_conv, ev_read, ev_err; // One-cycle events
	logic apb_do; // Access phase completes
	logic sclk_eff; // External clock after inversion
	logic slave_edge; // Active edge of the external clock

	// Format: MSB inverted gives twos complement when format pin is low
	function automatic logic [BITS-1:0] fmt(input logic [BITS-1:0] d, input logic ob);
		fmt = {d[BITS-1] ^ !ob, d[BITS-2:0]};
	endfunction

	assign apb_do = PSEL && PENABLE && PREADY;
	assign sclk_eff = sclk_s ^ cfg.serial_clock_invert;
	assign slave_edge = sclk_eff && !sclk_eff_d && cs_act;

	// ------------------------------------------------------------
	// Master clock divider
	// ------------------------------------------------------------
	asp_clkdiv u_div (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_run(state == ASP_MASTER),
		.i_code(cfg.serial_clock_divide),
		.o_tick(tick)
	);

	// ------------------------------------------------------------
	// Busy and result latch
	// ------------------------------------------------------------
	// Busy rises on start and falls once the result is latched
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_BUSY <= 1'b0;
			result <= '0;
		end else if (I_CONV_DONE) begin
			O_BUSY <= 1'b0;
			result <= fmt(I_CONV_DATA, cfg.output_format_select);
		end else if (I_CONV_START) begin
			O_BUSY <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Read sequence
	// ------------------------------------------------------------
	// Events of the read sequence, decoded once for status and state
	always_comb begin
		ev_conv = I_CONV_DONE;
		ev_err = I_CONV_DONE && state == ASP_SLAVE && bit_cnt < 5'(BITS);
		ev_read = 1'b0;
		if (state == ASP_MASTER && tick && sclk_int && bit_cnt == 5'(BITS - 1))
			ev_read = 1'b1;
		if (state == ASP_SLAVE && slave_edge && bit_cnt == 5'(BITS - 1))
			ev_read = 1'b1;
	end

	// Shifter, bit counter and clock level
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state <= ASP_IDLE;
			shreg <= '0;
			bit_cnt <= 5'h00;
			sclk_int <= 1'b0;
			sclk_eff_d <= 1'b0;
			rd_ok <= 1'b0;
		end else begin
			sclk_eff_d <= sclk_eff;
			if (I_CONV_DONE)
				rd_ok <= 1'b1;
			case (state)
				ASP_IDLE: begin
					bit_cnt <= 5'h00;
					sclk_int <= 1'b0;
					if (ctrl_en && cfg.serial && cfg.slave && cs_act) begin
						// Host clock: load latest result
						state <= ASP_SLAVE;
						shreg <= result;
					end else if (ctrl_en && cfg.serial && !cfg.slave) begin
						if (cfg.read_mode_or_chain_in && I_CONV_START) begin
							// Previous result goes out during conversion
							state <= ASP_MASTER;
							shreg <= result;
						end else if (!cfg.read_mode_or_chain_in && I_CONV_DONE) begin
							// Fresh result only after conversion ends
							state <= ASP_MASTER;
							shreg <= fmt(I_CONV_DATA, cfg.output_format_select);
						end
					end
				end
				ASP_MASTER: begin
					if (tick) begin
						sclk_int <= !sclk_int;
						if (sclk_int) begin
							shreg <= {shreg[BITS-2:0], 1'b0};
							bit_cnt <= bit_cnt + 5'h01;
							if (bit_cnt == 5'(BITS - 1)) begin
								state <= ASP_IDLE;
								rd_ok <= 1'b0;
							end
						end
					end
				end
				ASP_SLAVE: begin
					if (ev_err || !cs_act || !cfg.slave) begin
						// Unfinished read loses its data
						state <= ASP_IDLE;
					end else if (slave_edge) begin
						// Chain input fills in behind the result
						shreg <= {shreg[BITS-2:0], cfg.read_mode_or_chain_in};
						if (bit_cnt < 5'(BITS))
							bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == 5'(BITS - 1))
							rd_ok <= 1'b0;
					end
				end
				default: state <= ASP_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Serial pins
	// ------------------------------------------------------------
	// Registered pin drivers
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_SCLK <= 1'b0;
			O_SCLK_OE <= 1'b0;
			O_SERIAL_RESULT_OUT <= 1'b0;
			O_SYNC <= 1'b0;
			O_INCOMPLETE_READ_FLAG <= 1'b0;
		end else begin
			// Clock pin driven only by the master
			O_SCLK_OE <= cfg.serial && !cfg.slave;
			O_SCLK <= sclk_int ^ cfg.serial_clock_invert;
			O_SERIAL_RESULT_OUT <= (state != ASP_IDLE) ? shreg[BITS-1] : 1'b0;
			// Sync at its active level while master data is valid
			O_SYNC <= (state == ASP_MASTER) ^ cfg.sync_polarity_select;
			O_INCOMPLETE_READ_FLAG <= ev_err;
		end
	end

	// Shared pins: parallel bits or serial config inputs
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_SHARED <= 6'h00;
			O_SHARED_OE <= 6'h00;
		end else if (!cfg.serial) begin
			O_SHARED <= result[7:2];
			O_SHARED_OE <= 6'h3f;
		end else begin
			// Divide pins are high impedance in every serial mode
			O_SHARED <= 6'h00;
			O_SHARED_OE <= 6'h00;
		end
	end

	// ------------------------------------------------------------
	// APB registers and interrupt
	// ------------------------------------------------------------
	// One wait state per access keeps read data registered
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= PSEL && PENABLE && !PREADY && PADDR[1:0] != 2'h0;
			case (PADDR)
				`ASP_OFS_CTRL: PRDATA <= {31'h0, ctrl_en};
				`ASP_OFS_STATUS: PRDATA <= {29'h0, status};
				`ASP_OFS_MASK: PRDATA <= {29'h0, mask};
				`ASP_OFS_STATE: PRDATA <= {24'h0, cfg.serial, cfg.slave, rd_ok,
					bit_cnt == 5'(BITS), O_BUSY, 1'b0, state};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// Writable control and mask
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ctrl_en <= `ASP_CTRL_RST;
			mask <= `ASP_MASK_RST;
		end else if (apb_do && PWRITE) begin
			if (PADDR == `ASP_OFS_CTRL)
				ctrl_en <= PWDATA[`ASP_CTRL_EN];
			if (PADDR == `ASP_OFS_MASK)
				mask <= PWDATA[2:0];
		end
	end

	// Status clears on read; a same-cycle event wins over the clear
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			status <= 3'h0;
			O_IRQ <= 1'b0;
		end else begin
			status <= ((apb_do && !PWRITE && PADDR == `ASP_OFS_STATUS) ? 3'h0 : status)
				| {ev_err, ev_read, ev_conv};
			O_IRQ <= |(status & mask);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	property p_busy;
		I_CONV_START && !I_CONV_DONE |=> O_BUSY;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not raised");
	property p_busy_fall;
		I_CONV_DONE |=> !O_BUSY && result == fmt($past(I_CONV_DATA),
			$past(cfg.output_format_select));
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("result not latched");
	property p_par;
		!cfg.serial |=> O_SHARED_OE == 6'h3f;
	endproperty
	a_par: assert property (p_par) else $error("parallel pins not driven");
	property p_div_hiz;
		cfg.serial && $stable(cfg.serial) |=> O_SHARED_OE[1:0] == 2'h0;
	endproperty
	a_div_hiz: assert property (p_div_hiz) else $error("divide pins driven");
	property p_sync;
		state == ASP_MASTER && $stable(cfg.sync_polarity_select)
			|=> O_SYNC == !cfg.sync_polarity_select;
	endproperty
	a_sync: assert property (p_sync) else $error("sync level wrong");
	property p_err;
		state == ASP_SLAVE && I_CONV_DONE && bit_cnt < 5'(BITS)
			|=> O_INCOMPLETE_READ_FLAG && state == ASP_IDLE;
	endproperty
	a_err: assert property (p_err) else $error("incomplete read not flagged");
	property p_rdc_wait;
		state == ASP_IDLE && !cfg.slave && !cfg.read_mode_or_chain_in && !I_CONV_DONE
			|=> state != ASP_MASTER;
	endproperty
	a_rdc_wait: assert property (p_rdc_wait) else $error("early master read");
	property p_during;
		state == ASP_IDLE && ctrl_en && cfg.serial && !cfg.slave
			&& cfg.read_mode_or_chain_in && I_CONV_START |=> state == ASP_MASTER;
	endproperty
	a_during: assert property (p_during) else $error("read-during not started");
	property p_master_clk;
		cfg.serial && !cfg.slave && $stable(cfg) |=> O_SCLK_OE
			&& O_SCLK == ($past(sclk_int) ^ $past(cfg.serial_clock_invert));
	endproperty
	a_master_clk: assert property (p_master_clk) else $error("master clock wrong");
	property p_chain;
		state == ASP_SLAVE && slave_edge && !ev_err && cs_act && cfg.slave
			|=> shreg[0] == $past(cfg.read_mode_or_chain_in);
	endproperty
	a_chain: assert property (p_chain) else $error("chain bit lost");
	c_master: cover property (state == ASP_MASTER ##1 state == ASP_IDLE);
	c_slave: cover property (state == ASP_SLAVE && bit_cnt == 5'(BITS));
	c_err: cover property (O_INCOMPLETE_READ_FLAG);
	c_irq: cover property (O_IRQ);
endmodule

// ### asp_host.sv
// ------------------------------------------------------------
// Host serial port model
// ------------------------------------------------------------
module asp_host (
	// Bench control
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic i_report,
	input wire logic [4:0] i_edges,
	input wire logic i_inv,
	input wire logic i_pol,
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_serial_result_out,
	input wire logic i_sync,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_rd_n,
	// Captured word
	output logic o_valid,
	output logic [15:0] o_word,
	output logic [15:0] o_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] sh; // Receive shift register
	logic prev; // Last clock level seen
	int len; // Frame length in cycles
	// One process, so slave reads and frame capture never race
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_valid = 1'b0;
		o_word = 16'h0000;
		o_len = 16'h0000;
		forever begin
			@(posedge i_clk);
			o_valid <= 1'b0;
			if (i_go) begin
				// Clock only while selected; it stands still between frames
				o_cs_n <= 1'b0;
				o_rd_n <= 1'b0;
				repeat (8) @(posedge i_clk);
				for (int k = 0; k < i_edges; k++) begin
					// Sample late in the bit, just before the shifting edge
					sh = {sh[14:0], i_serial_result_out};
					o_sclk <= ~i_inv;
					repeat (8) @(posedge i_clk);
					o_sclk <= i_inv;
					repeat (8) @(posedge i_clk);
				end
				o_cs_n <= 1'b1;
				o_rd_n <= 1'b1;
				if (i_report) begin
					o_word <= sh;
					o_valid <= 1'b1;
				end
			end else if (i_report && i_sync !== i_pol) begin
				// Listen to a master frame, sampling on rising clock
				len = 0;
				prev = i_sclk;
				while (i_sync !== i_pol && len < 5000) begin
					if (i_sclk && !prev) sh = {sh[14:0], i_serial_result_out};
					prev = i_sclk;
					len++;
					@(posedge i_clk);
				end
				o_word <= sh;
				o_len <= len[15:0];
				o_valid <= 1'b1;
			end
		end
	end
endmodule

// ### asp_top_tb.sv
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module asp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_CLK, I_RESETN, I_CONV_START, I_CONV_DONE, I_SERIAL_PARALLEL_SELECT;
	logic I_OUTPUT_FORMAT_SELECT, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic O_SCLK, O_SCLK_OE, O_SERIAL_RESULT_OUT, O_SYNC, O_INCOMPLETE_READ_FLAG, O_BUSY, O_IRQ;
	logic [15:0] I_CONV_DATA, d, prev, e, h_word, h_len, e_w;
	logic [5:0] cfg, O_SHARED, O_SHARED_OE; // Pin levels the board puts on shared pins
	logic [3:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [32:0] e_rd, q_rd[$]; // Expected {error, data} of reads
	logic [15:0] q_word[$]; // Expected serial words
	logic h_go, h_report, h_sclk, h_cs_n, h_rd_n, h_valid, c, e1;
	logic [4:0] h_edges;
	int num_errors = 0, n_compared = 0, seed = 12, hp;
	// Resolve each shared wire from whoever enables it
	wire logic [5:0] shared_w = (O_SHARED & O_SHARED_OE) | (cfg & ~O_SHARED_OE);
	wire logic sclk_w = O_SCLK_OE ? O_SCLK : h_sclk;
	asp_top asp_top_i (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_CONV_START(I_CONV_START),
		.I_CONV_DONE(I_CONV_DONE), .I_CONV_DATA(I_CONV_DATA),
		.I_SERIAL_PARALLEL_SELECT(I_SERIAL_PARALLEL_SELECT),
		.I_OUTPUT_FORMAT_SELECT(I_OUTPUT_FORMAT_SELECT), .I_CS_N(h_cs_n), .I_RD_N(h_rd_n),
		.I_SHARED(shared_w), .O_SHARED(O_SHARED), .O_SHARED_OE(O_SHARED_OE), .I_SCLK(sclk_w),
		.O_SCLK(O_SCLK), .O_SCLK_OE(O_SCLK_OE), .O_SERIAL_RESULT_OUT(O_SERIAL_RESULT_OUT),
		.O_SYNC(O_SYNC), .O_INCOMPLETE_READ_FLAG(O_INCOMPLETE_READ_FLAG), .O_BUSY(O_BUSY),
		.O_IRQ(O_IRQ), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
	asp_host asp_host_i (.i_clk(I_CLK), .i_go(h_go), .i_report(h_report), .i_edges(h_edges),
		.i_inv(cfg[4]), .i_pol(cfg[3]), .i_sclk(sclk_w), .i_serial_result_out(O_SERIAL_RESULT_OUT),
		.i_sync(O_SYNC), .o_sclk(h_sclk), .o_cs_n(h_cs_n), .o_rd_n(h_rd_n),
		.o_valid(h_valid), .o_word(h_word), .o_len(h_len));
	// 200 MHz clock
	initial begin
		I_CLK = 1'b0;
		forever #2.5 I_CLK = ~I_CLK;
	end
	// Result watcher: oldest note against each answer
	always @(posedge I_CLK) begin
		if (PSEL && PENABLE && PREADY && !PWRITE) begin
			e_rd = q_rd.pop_front();
			`CHK("apb read", e_rd, {PSLVERR, PSLVERR ? 32'h0 : PRDATA})
		end
		if (h_valid) begin
			e_w = q_word.pop_front();
			`CHK("serial word", e_w, h_word)
		end
	end
	function automatic logic [15:0] fmt(input logic [15:0] v, input logic b);
		fmt = b ? v : {~v[15], v[14:0]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge I_CLK);
	endtask
	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// APB transfer; holds everything until pready is sampled
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] dat);
		int n;
		@(posedge I_CLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, dat};
		@(posedge I_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge I_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			$display("[FAIL] pready expected 1 seen 0");
			give_verdict;
		end
	endtask
	// Conversion start or done pulse
	task automatic pulse(input logic st, input logic [15:0] v);
		@(posedge I_CLK);
		if (st) I_CONV_START <= 1'b1;
		else {I_CONV_DONE, I_CONV_DATA} <= {1'b1, v};
		@(posedge I_CLK);
		I_CONV_START <= 1'b0;
		I_CONV_DONE <= 1'b0;
	endtask
	// Bounded wait until every noted word has arrived
	task automatic drain;
		int n;
		n = 0;
		while (q_word.size() != 0 && n < 6000) begin
			tick(1);
			n++;
		end
		if (n >= 6000) begin
			num_errors++;
			$display("[FAIL] serial word expected 1 seen 0");
			give_verdict;
		end
	endtask
	task automatic host(input logic [4:0] n, input logic rep);
		h_edges <= n;
		h_report <= rep;
		h_go <= 1'b1;
		tick(1);
		h_go <= 1'b0;
	endtask
	initial begin
		{I_RESETN, I_CONV_START, I_CONV_DONE, I_CONV_DATA, cfg} = '0;
		{I_SERIAL_PARALLEL_SELECT, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{h_go, h_report, h_edges, I_OUTPUT_FORMAT_SELECT} = 7'h01;
		tick(10);
		I_RESETN <= 1'b1;
		tick(3);
		// Reset values, refused address, interrupt raise, clear and mask
		q_rd = '{{1'b0, 32'h1}, 33'h0, 33'h0, {1'b1, 32'h0}};
		apb(1'b0, 4'h0, 32'h0);
		apb(1'b0, 4'h8, 32'h0);
		apb(1'b0, 4'h4, 32'h0);
		apb(1'b0, 4'h2, 32'h0);
		apb(1'b1, 4'h8, 32'h1);
		d = 16'($random(seed));
		pulse(1'b1, 16'h0);
		tick(2);
		`CHK("busy", 1'b1, O_BUSY)
		pulse(1'b0, d);
		tick(3);
		e = fmt(d, 1'b1);
		`CHK("busy", 1'b0, O_BUSY)
		`CHK("irq", 1'b1, O_IRQ)
		`CHK("parallel bits", e[7:2], O_SHARED)
		`CHK("parallel enable", 6'h3f, O_SHARED_OE)
		q_rd.push_back({1'b0, 32'h1});
		apb(1'b0, 4'h4, 32'h0);
		tick(3);
		`CHK("irq", 1'b0, O_IRQ)
		apb(1'b1, 4'h8, 32'h0);
		pulse(1'b0, d);
		tick(3);
		`CHK("irq", 1'b0, O_IRQ)
		q_rd.push_back({1'b0, 32'h1});
		apb(1'b0, 4'h4, 32'h0);
		prev = d;
		$display("registers and interrupt test done");
		// Master reads: every divide code, both polarities and formats, read-during last
		I_SERIAL_PARALLEL_SELECT <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			cfg <= {k == 4, 1'b0, k[0], 1'b0, (k == 4) ? 2'h3 : k[1:0]};
			I_OUTPUT_FORMAT_SELECT <= (k == 4) | k[1];
			tick(6);
			`CHK("sync idle", k[0], O_SYNC)
			`CHK("divide pins released", 6'h00, O_SHARED_OE)
			`CHK("clock driven", 1'b1, O_SCLK_OE)
			h_report <= 1'b1;
			d = 16'($random(seed));
			hp = (k == 4) ? 2 : (2 << k);
			if (k == 4) begin
				q_word.push_back(fmt(prev, 1'b1));
				pulse(1'b1, 16'h0);
				drain;
				pulse(1'b0, d);
			end else begin
				q_word.push_back(fmt(d, k[1]));
				pulse(1'b0, d);
				drain;
			end
			`CHK("frame length", 1'b1, h_len >= 32 * hp && h_len <= 32 * hp + 4)
			h_report <= 1'b0;
			prev = d;
		end
		cfg <= cfg | 6'h10;
		tick(6);
		e1 = O_SCLK;
		cfg[4] <= 1'b0;
		tick(6);
		`CHK("clock sense", ~e1, O_SCLK)
		$display("master test done");
		// Slave: daisy-chain level after 16 clocks, then an aborted read
		c = 1'($random(seed));
		cfg <= {c, 5'h04};
		tick(6);
		`CHK("clock released", 1'b0, O_SCLK_OE)
		d = 16'($random(seed));
		pulse(1'b0, d);
		e = fmt(d, 1'b1);
		q_word.push_back({e[14:0], c});
		host(5'd17, 1'b1);
		drain;
		tick(4);
		pulse(1'b0, 16'($random(seed)));
		host(5'd16, 1'b0);
		tick(40);
		pulse(1'b0, 16'($random(seed)));
		for (int n = 0; n < 20 && O_INCOMPLETE_READ_FLAG !== 1'b1; n++) tick(1);
		`CHK("incomplete flag", 1'b1, O_INCOMPLETE_READ_FLAG)
		tick(300);
		$display("slave test done");
		give_verdict;
	end
endmodule
